// ==== srctl_top.sv ====
// Run-state controller of a step sequencer
// What this block does
// - Editing state never runs; any load or edit needs a new check pass.
// - Check in editing validates, allocates memory, picks range, then arms on pass.
// - Failed validation flags error and stays in editing.
// - Editing drives output with the selected step's configuration.
// - Cutting or inserting steps leaves jump and branch destinations unchanged.
// - Saving allowed only in editing, before or after a check.
// - Start in armed begins running.
// - Pause in running holds step and output unchanged.
// - Resume in paused continues from the paused point.
// - Branch command in run or pause jumps only if step enables event branch.
// - Stop in run or pause selects step zero and returns to armed.
// - Immediate stop ends at once, step zero, no phase or sweep wait.
// - Edit in armed returns to editing, needing a new check.
// - External lines other than the trigger act only when external control is enabled.
// - Trigger input used as sequence trigger only starts the sequence.
// - External start falling edge starts when armed, ignored in run or pause.
// - External stop falling edge in run or pause ends, step zero.
// - External pause falls to pause in run, rises to resume when paused.
// - External event falling edge branches if step enables event branch.
// - Low external state line branches if step enables state branch.
// - Shared input is start or state branch, never both.
// - A setting assigns the shared input to start or state branch.
// - Auto output gate turns output on at start from armed, off on stop or sequence end.
`timescale 1ns/1ps
`default_nettype none
module srctl_top
    import srctl_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire srctl_cmd_t        panel_cmd,
    input  wire srctl_ext_t        ext_in,
    input  wire srctl_step_t       step_info,
    input  wire logic              external_control_enable,
    input  wire logic              shared_input_assign,
    input  wire logic              trigger_as_start,
    input  wire logic              auto_output_gate,
    input  wire logic              output_key_toggle,
    input  wire logic              check_done,
    input  wire logic              check_pass,
    input  wire logic              edit_modify,
    input  wire logic [STEP_W-1:0] edit_step_select,
    output logic                   check_request,
    output logic                   check_error,
    output logic                   store_grant,
    output logic                   step_advance_enable,
    output logic                   abort_now,
    output logic                   waveform_output,
    output srctl_state_t           run_state,
    output logic [STEP_W-1:0]      active_step
);
    ////////////////////////////////////////////////////////////////////////
    // External line conditioning
    logic start_fall, stop_fall, pause_fall, pause_rise;
    logic event_fall, shared_lvl, shared_fall, trig_rise;

    srctl_edge u_start (.mclk(mclk), .resetn(resetn), .din(ext_in.start_n),
        .level(), .fall(start_fall), .rise());
    srctl_edge u_stop (.mclk(mclk), .resetn(resetn), .din(ext_in.stop_n),
        .level(), .fall(stop_fall), .rise());
    srctl_edge u_pause (.mclk(mclk), .resetn(resetn), .din(ext_in.pause_n),
        .level(), .fall(pause_fall), .rise(pause_rise));
    srctl_edge u_event (.mclk(mclk), .resetn(resetn), .din(ext_in.event_n),
        .level(), .fall(event_fall), .rise());
    srctl_edge u_shared (.mclk(mclk), .resetn(resetn), .din(ext_in.shared_n),
        .level(shared_lvl), .fall(shared_fall), .rise());
    // Trigger idles low, so its reset-time fall is never used
    srctl_edge u_trig (.mclk(mclk), .resetn(resetn), .din(ext_in.trigger),
        .level(), .fall(), .rise(trig_rise));

    ////////////////////////////////////////////////////////////////////////
    // Command merge
    wire ext_en        = external_control_enable;
    // Shared pin is start when assign is low, state branch when high
    wire shared_is_lvl = shared_input_assign;
    wire x_start  = ext_en & ((start_fall) | (~shared_is_lvl & shared_fall));
    wire t_start  = trigger_as_start & trig_rise;
    wire x_stop   = ext_en & stop_fall;
    wire x_pause  = ext_en & pause_fall;
    wire x_resume = ext_en & pause_rise;
    wire x_event  = ext_en & event_fall;
    wire x_state  = ext_en & shared_is_lvl & ~shared_lvl;

    wire in_edit  = (run_state == SRC_EDIT);
    wire in_armed = (run_state == SRC_ARMED);
    wire in_run   = (run_state == SRC_RUN);
    wire in_pause = (run_state == SRC_PAUSE);
    wire active   = in_run | in_pause;

    wire do_abort  = active & panel_cmd.abort_now_cmd;
    wire do_stop   = active & (panel_cmd.stop | x_stop);
    wire term      = do_abort | do_stop;
    wire do_start  = in_armed & (panel_cmd.start | x_start | t_start);
    wire do_edit   = in_armed & panel_cmd.edit & ~do_start;
    wire ev_req    = panel_cmd.branch_event_cmd | x_event;
    wire do_event  = active & ~term & ev_req & step_info.event_branch_on;
    wire do_state  = active & ~term & ~do_event & x_state
                   & step_info.state_branch_on;
    wire do_pause  = in_run & ~term & ~do_event & ~do_state
                   & (panel_cmd.pause | x_pause);
    wire do_resume = in_pause & ~term & ~do_event & ~do_state
                   & (panel_cmd.resume | x_resume);

    ////////////////////////////////////////////////////////////////////////
    // Check handshake
    logic checking;
    wire  do_check   = in_edit & panel_cmd.check & ~checking & ~edit_modify;
    wire  check_ok   = checking & check_done & check_pass & ~edit_modify;
    wire  check_bad  = checking & check_done & (~check_pass | edit_modify);

    srctl_state_t next_run_state;
    always_comb begin
        next_run_state = run_state;
        unique case (run_state)
            SRC_EDIT: begin
                if (check_ok) begin
                    next_run_state = SRC_ARMED;
                end
            end
            SRC_ARMED: begin
                if (do_start) begin
                    next_run_state = SRC_RUN;
                end else if (do_edit) begin
                    next_run_state = SRC_EDIT;
                end
            end
            SRC_RUN: begin
                if (term) begin
                    next_run_state = SRC_ARMED;
                end else if (do_pause) begin
                    next_run_state = SRC_PAUSE;
                end
            end
            SRC_PAUSE: begin
                if (term) begin
                    next_run_state = SRC_ARMED;
                end else if (do_resume) begin
                    next_run_state = SRC_RUN;
                end
            end
            default: next_run_state = SRC_EDIT;
        endcase
    end

    // Step selection: in editing the panel choice drives the output
    logic [STEP_W-1:0] next_active_step;
    always_comb begin
        next_active_step = active_step;
        if (in_edit) begin
            next_active_step = edit_step_select;
        end else if (term) begin
            next_active_step = STEP_ZERO;
        end else if (do_start) begin
            next_active_step = STEP_ZERO;
        end else if (do_event) begin
            next_active_step = step_info.event_dest;
        end else if (do_state) begin
            next_active_step = step_info.state_dest;
        end else if (in_run & step_info.step_done & ~do_pause) begin
            // Destinations pass through untouched; no renumbering here
            next_active_step = step_info.next_step;
        end
    end

    // Natural sequence end returns to armed via the step logic's own stop
    // A branch in the same cycle outranks the natural end
    wire seq_finish = in_run & step_info.seq_end & ~term & ~do_event & ~do_state;

    ////////////////////////////////////////////////////////////////////////
    // Output gate: key toggles work unless the auto gate acts that cycle, auto gate acts on entry
    logic next_wave;
    always_comb begin
        next_wave = waveform_output;
        if (output_key_toggle) begin
            next_wave = ~waveform_output;
        end
        if (auto_output_gate & do_start) begin
            next_wave = 1'b1;
        end else if (auto_output_gate & (term | seq_finish)) begin
            next_wave = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_state <= SRC_EDIT;
        end else if (seq_finish) begin
            run_state <= SRC_ARMED;
        end else begin
            run_state <= next_run_state;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            active_step <= STEP_ZERO;
        end else if (seq_finish) begin
            active_step <= STEP_ZERO;
        end else begin
            active_step <= next_active_step;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            checking <= 1'b0;
        end else if (do_check) begin
            checking <= 1'b1;
        end else if (check_done | ~in_edit) begin
            checking <= 1'b0;
        end
    end

    // Error is sticky until the next check request or leaving editing
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            check_error <= 1'b0;
        end else if (check_bad) begin
            check_error <= 1'b1;
        end else if (do_check | ~in_edit) begin
            check_error <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            check_request <= 1'b0;
            store_grant   <= 1'b0;
            abort_now     <= 1'b0;
        end else begin
            check_request <= do_check;
            store_grant   <= in_edit & panel_cmd.store;
            abort_now     <= do_abort;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            waveform_output <= 1'b0;
        end else begin
            waveform_output <= next_wave;
        end
    end

    // Steps advance only while running; paused holds the step unless a branch or stop acts
    assign step_advance_enable = in_run;
endmodule : srctl_top
`default_nettype wire

// ==== srctl_pkg.sv ====
// Shared types and constants for the sequence run control block
package srctl_pkg;

    localparam int STEP_W = 8;

    localparam logic [STEP_W-1:0] STEP_ZERO  = 8'h00;
    localparam logic [1:0]        SYNC_RESET = 2'h3;

    typedef enum logic [3:0] {
        SRC_EDIT  = 4'b0001,
        SRC_ARMED = 4'b0010,
        SRC_RUN   = 4'b0100,
        SRC_PAUSE = 4'b1000
    } srctl_state_t;

    // Panel key commands, each a one-cycle pulse
    typedef struct packed {
        logic check;
        logic start;
        logic pause;
        logic resume;
        logic branch_event_cmd;
        logic stop;
        logic abort_now_cmd;
        logic edit;
        logic store;
    } srctl_cmd_t;

    // External logic-level lines, high at rest except the trigger, which rests low
    typedef struct packed {
        logic start_n;
        logic stop_n;
        logic pause_n;
        logic event_n;
        logic shared_n;
        logic trigger;
    } srctl_ext_t;

    // Branch attributes of the active step
    typedef struct packed {
        logic              event_branch_on;
        logic [STEP_W-1:0] event_dest;
        logic              state_branch_on;
        logic [STEP_W-1:0] state_dest;
        logic [STEP_W-1:0] next_step;
        logic              step_done;
        logic              seq_end;
    } srctl_step_t;

endpackage : srctl_pkg

// ==== srctl_edge.sv ====
// Two-flop synchroniser with edge detection for one external line
`timescale 1ns/1ps
`default_nettype none
module srctl_edge
    import srctl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      level,
    output logic      fall,
    output logic      rise
);
    logic [1:0] sync;
    logic       prev;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync <= SYNC_RESET;
            prev <= 1'b1;
        end else begin
            sync <= {sync[0], din};
            prev <= sync[1];
        end
    end

    assign level = sync[1];
    assign fall  = prev & ~sync[1];
    assign rise  = ~prev & sync[1];
endmodule : srctl_edge
`default_nettype wire

// ==== srctl_top_props.sv ====
// Concurrent checks on the run controller ports
`timescale 1ns/1ps
`default_nettype none
module srctl_top_props
    import srctl_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire srctl_cmd_t        panel_cmd,
    input  wire srctl_step_t       step_info,
    input  wire logic              auto_output_gate,
    input  wire logic              check_done,
    input  wire logic              check_pass,
    input  wire logic              edit_modify,
    input  wire logic              check_request,
    input  wire logic              check_error,
    input  wire logic              store_grant,
    input  wire logic              step_advance_enable,
    input  wire logic              waveform_output,
    input  wire srctl_state_t      run_state,
    input  wire logic [STEP_W-1:0] active_step
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire live = run_state == SRC_RUN || run_state == SRC_PAUSE;
    wire term = (panel_cmd.stop || panel_cmd.abort_now_cmd) && live;
    wire armed = run_state == SRC_ARMED;
    ////////////////////////////////////////////////////////////////////////////////
    property p_adv; step_advance_enable == (run_state == SRC_RUN); endproperty
    a_adv: assert property (p_adv) else $error("advance enable outside run");
    property p_chkreq; check_request |-> $past(panel_cmd.check && run_state == SRC_EDIT); endproperty
    a_chkreq: assert property (p_chkreq) else $error("check request without check");
    property p_arm; armed && $past(run_state) == SRC_EDIT |-> $past(check_done && check_pass);
    endproperty
    a_arm: assert property (p_arm) else $error("armed without passing check");
    property p_fail;
        $rose(check_error) |-> $past(check_done && (!check_pass || edit_modify)) && !armed;
    endproperty
    a_fail: assert property (p_fail) else $error("error flag without failed check");
    property p_store; store_grant |-> $past(panel_cmd.store && run_state == SRC_EDIT); endproperty
    a_store: assert property (p_store) else $error("store granted outside edit");
    property p_start; panel_cmd.start && armed |=> run_state == SRC_RUN && active_step == STEP_ZERO;
    endproperty
    a_start: assert property (p_start) else $error("start did not run");
    property p_pause;
        panel_cmd.pause && run_state == SRC_RUN && !term && !panel_cmd.branch_event_cmd
            && !step_info.event_branch_on && !step_info.state_branch_on && !step_info.seq_end
            |=> run_state == SRC_PAUSE && $stable(active_step);
    endproperty
    a_pause: assert property (p_pause) else $error("pause did not hold");
    property p_stop; term |=> armed && active_step == STEP_ZERO; endproperty
    a_stop: assert property (p_stop) else $error("stop did not reach step zero");
    property p_edit; panel_cmd.edit && armed && !panel_cmd.start |=> run_state == SRC_EDIT;
    endproperty
    a_edit: assert property (p_edit) else $error("edit did not return");
    property p_auto; auto_output_gate && armed ##1 run_state == SRC_RUN |-> waveform_output;
    endproperty
    a_auto: assert property (p_auto) else $error("output not on at run");
    property p_branch;
        panel_cmd.branch_event_cmd && live && step_info.event_branch_on && !term
            |=> active_step == $past(step_info.event_dest);
    endproperty
    a_branch: assert property (p_branch) else $error("event branch missed");
endmodule : srctl_top_props
bind srctl_top srctl_top_props u_props (.mclk, .resetn, .panel_cmd, .step_info,
    .auto_output_gate, .check_done, .check_pass, .edit_modify, .check_request, .check_error,
    .store_grant,
    .step_advance_enable, .waveform_output, .run_state, .active_step);
`default_nettype wire

// ==== srctl_far_side.sv ====
// External control lines as the far side presents them
`timescale 1ns/1ps
`default_nettype none
module srctl_far_side
    import srctl_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire srctl_ext_t want,
    output var  srctl_ext_t ext_in
);
    // Lines rest high, trigger rests low; no noise injected
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) ext_in <= srctl_ext_t'(6'h3E);
        else ext_in <= want;
    end
endmodule : srctl_far_side
`default_nettype wire

// ==== srctl_top_bench.sv ====
// Directed bench for the run controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module srctl_top_bench
    import srctl_pkg::*;
;
    logic         mclk = 1'b0;
    logic         resetn = 1'b0;
    srctl_cmd_t   panel_cmd = '0;
    srctl_ext_t   want = srctl_ext_t'(6'h3E);
    srctl_ext_t   ext_in;
    srctl_step_t  si = '0;
    logic         ext_en = 1'b0;
    logic         share_sel = 1'b0;
    logic         trig_start = 1'b0;
    logic         chk_done = 1'b0;
    logic         chk_pass = 1'b0;
    logic         auto_gate = 1'b1;
    logic         modify = 1'b0;
    logic [7:0]   sel = 8'h00;
    logic         chk_req, chk_err, grant, adv, abort_now, wave;
    srctl_state_t state;
    logic [7:0]   step;
    int           n_fail = 0;
    int           n_tests = 0;
    srctl_top u_dut (.mclk(mclk), .resetn(resetn), .panel_cmd(panel_cmd), .ext_in(ext_in),
        .step_info(si), .external_control_enable(ext_en), .shared_input_assign(share_sel),
        .trigger_as_start(trig_start), .auto_output_gate(auto_gate), .output_key_toggle(1'b0),
        .check_done(chk_done), .check_pass(chk_pass), .edit_modify(modify),
        .edit_step_select(sel), .check_request(chk_req), .check_error(chk_err),
        .store_grant(grant), .step_advance_enable(adv), .abort_now(abort_now),
        .waveform_output(wave), .run_state(state), .active_step(step));
    srctl_far_side u_far (.mclk(mclk), .resetn(resetn), .want(want), .ext_in(ext_in));
    initial begin
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic key(input logic [8:0] k);
        @(posedge mclk) panel_cmd <= srctl_cmd_t'(k);
        @(posedge mclk) panel_cmd <= '0;
        #1;
    endtask : key
    // Synchroniser plus edge register need several cycles
    task automatic pin(input logic [5:0] v);
        @(posedge mclk) want <= srctl_ext_t'(v);
        repeat (7) @(posedge mclk);
        #1;
    endtask : pin
    task automatic check_run(input logic pass);
        key(9'h100);
        `CHK("check_request", 1'b1, chk_req)
        @(posedge mclk) chk_done <= 1'b1;
        chk_pass <= pass;
        @(posedge mclk) chk_done <= 1'b0;
        #1;
    endtask : check_run
    task automatic st(input srctl_state_t s, input logic [7:0] n);
        `CHK("run_state", s, state)
        `CHK("active_step", n, step)
    endtask : st
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk);
        @(posedge mclk) resetn <= 1'b1;
        sel <= 8'h05;
        repeat (3) @(posedge mclk);
        #1;
        st(SRC_EDIT, 8'h05);
        key(9'h080);
        st(SRC_EDIT, 8'h05);
        key(9'h001);
        `CHK("store_grant", 1'b1, grant)
        check_run(1'b0);
        `CHK("check_error", 1'b1, chk_err)
        st(SRC_EDIT, 8'h05);
        check_run(1'b1);
        `CHK("run_state", SRC_ARMED, state)
        key(9'h001);
        `CHK("store_grant", 1'b0, grant)
        key(9'h002);
        `CHK("run_state", SRC_EDIT, state)
        @(posedge mclk) modify <= 1'b1;
        key(9'h100);
        `CHK("check_request", 1'b0, chk_req)
        @(posedge mclk) modify <= 1'b0;
        check_run(1'b1);
        key(9'h080);
        st(SRC_RUN, 8'h00);
        `CHK("waveform_output", 1'b1, wave)
        @(posedge mclk) si.step_done <= 1'b1;
        si.next_step <= 8'h03;
        @(posedge mclk) si.step_done <= 1'b0;
        key(9'h040);
        st(SRC_PAUSE, 8'h03);
        `CHK("step_advance_enable", 1'b0, adv)
        key(9'h020);
        st(SRC_RUN, 8'h03);
        key(9'h010);
        st(SRC_RUN, 8'h03);
        @(posedge mclk) si.event_branch_on <= 1'b1;
        si.event_dest <= 8'h2A;
        key(9'h010);
        st(SRC_RUN, 8'h2A);
        key(9'h018);
        st(SRC_ARMED, 8'h00);
        `CHK("waveform_output", 1'b0, wave)
        key(9'h080);
        key(9'h004);
        `CHK("abort_now", 1'b1, abort_now)
        st(SRC_ARMED, 8'h00);
        pin(6'h1E);
        `CHK("run_state", SRC_ARMED, state)
        pin(6'h3E);
        @(posedge mclk) ext_en <= 1'b1;
        pin(6'h1E);
        `CHK("run_state", SRC_RUN, state)
        pin(6'h36);
        st(SRC_PAUSE, 8'h00);
        pin(6'h3E);
        `CHK("run_state", SRC_RUN, state)
        pin(6'h3A);
        st(SRC_RUN, 8'h2A);
        @(posedge mclk) share_sel <= 1'b1;
        si.state_branch_on <= 1'b1;
        si.state_dest <= 8'h11;
        pin(6'h3C);
        st(SRC_RUN, 8'h11);
        pin(6'h2E);
        st(SRC_ARMED, 8'h00);
        pin(6'h2C);
        `CHK("run_state", SRC_ARMED, state)
        @(posedge mclk) trig_start <= 1'b1;
        pin(6'h3F);
        `CHK("run_state", SRC_RUN, state)
        @(posedge mclk) si.seq_end <= 1'b1;
        @(posedge mclk) si.seq_end <= 1'b0;
        #1;
        st(SRC_ARMED, 8'h00);
        `CHK("waveform_output", 1'b0, wave)
        @(posedge mclk) auto_gate <= 1'b0;
        key(9'h080);
        `CHK("run_state", SRC_RUN, state)
        `CHK("waveform_output", 1'b0, wave)
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        print_verdict;
    end
endmodule : srctl_top_bench
`default_nettype wire
